// [pgc_top.v]
// PWM generator control, duty registers, chop clock and Wishbone slave
//
// Functional notes
// - Compare value in bits 15..3, low bits zero
// - Chop clock runs only while enabled
// - Chop period set by seven-bit divider field
// - Chop clock counts prescaled input ticks
// - Duty clamped between 8 and period minus 8
// - Resolution coarsens near 0% and 100%; this design only clamps there, the duty step size does not change
// - Dead-time control: positive, negative, off, reserved
// - Time base select picks secondary master base
// - Center align honoured only with independent time base
// - Center mode drops three duty low bits
// - Limit input resets independent time base
// - Immediate update bypasses cycle-boundary shadowing
// - Primary duty drives high, or both outputs
// - Secondary duty drives low in independent mode
// - Prescaler codes divide by 1 to 64
//
// The address map and the Wishbone slave port are this design's own decisions.
`default_nettype none
`include "pgc_regs.vh"
module pgc_top #(
  parameter HAS_SEC_BASE = 0
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Neighbouring blocks
  input wire [1:0] output_mode_i,
  input wire current_limit_mode_i,
  input wire fault_pending_i,
  input wire limit_pending_i,
  input wire [15:0] sec_base_count_i,
  input wire sec_base_tick_i,
  // Power stage and events
  output reg high_output_o,
  output reg low_output_o,
  output reg chop_clk_o,
  output reg special_event_o,
  output reg gen_irq_o
);
  // Output modes and dead-time codes
  localparam MODE_INDEP = 2'h3;
  localparam DTC_POS = 2'h0;
  localparam DTC_NEG = 2'h1;
  localparam DTC_OFF = 2'h2;

  // Software registers
  reg [2:0] input_clock_prescaler_ff;
  reg module_master_enable_ff;
  reg [15:0] master_period_ff;
  reg [12:0] secondary_event_compare_value_ff;
  reg chop_generator_enable_ff;
  reg [6:0] chop_divider_ff;
  reg [15:0] shared_duty_ff;
  reg [15:0] protection_key_value_ff;
  reg fault_irq_flag_ff;
  reg limit_irq_flag_ff;
  reg trigger_irq_flag_ff;
  reg fault_irq_enable_ff;
  reg limit_irq_enable_ff;
  reg trigger_irq_enable_ff;
  reg independent_period_select_ff;
  reg shared_duty_select_ff;
  reg [1:0] dead_time_control_ff;
  reg time_base_select_ff;
  reg center_align_enable_ff;
  reg external_period_reset_ff;
  reg immediate_update_ff;
  reg [15:0] primary_duty_value_ff;
  reg [15:0] secondary_duty_value_ff;
  reg [15:0] primary_phase_value_ff;
  reg [15:0] secondary_phase_value_ff;
  // Dead-time delay stage
  reg high_dly_ff;
  reg low_dly_ff;

  // Wires
  wire tick;
  wire chop;
  wire core_high;
  wire core_low;
  wire cycle_end;
  wire match;
  wire [15:0] count;
  wire wr;
  wire rd;
  wire [15:0] wdat;
  wire [15:0] nxt_ctrl;
  wire use_sec;
  wire gen_tick;
  wire center;
  wire indep_mode;
  wire [15:0] period;
  wire [15:0] duty_src;
  wire [15:0] duty_h;
  wire [15:0] duty_l;
  wire ext_rst;
  wire [15:0] cmp_merge;
  wire [15:0] chop_merge;
  reg [15:0] rd_val;
  reg nxt_high;
  reg nxt_low;

  // Clamp a duty into the legal pulse window
  function [15:0] clamp_duty;
    input [15:0] duty;
    input [15:0] per;
    input ctr;
    reg [15:0] hi;
    reg [15:0] d;
    begin
      hi = (per > `PGC_DUTY_MIN) ? per - `PGC_DUTY_MIN : `PGC_DUTY_MIN;
      d = ctr ? {duty[15:3], 3'h0} : duty;
      if (d < `PGC_DUTY_MIN) begin
        clamp_duty = `PGC_DUTY_MIN;
      end else if (d > hi) begin
        clamp_duty = hi;
      end else begin
        clamp_duty = d;
      end
    end
  endfunction

  // Merge byte lanes of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] dat;
    input [1:0] sel;
    begin
      merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  // Bus strobes, one access per ack
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  // Control register image for byte merging
  assign nxt_ctrl = merge16({fault_irq_flag_ff, limit_irq_flag_ff, trigger_irq_flag_ff,
    fault_irq_enable_ff, limit_irq_enable_ff, trigger_irq_enable_ff,
    independent_period_select_ff, shared_duty_select_ff, dead_time_control_ff, 2'h0,
    time_base_select_ff, center_align_enable_ff, external_period_reset_ff,
    immediate_update_ff}, wb_dat_i[15:0], wb_sel_i[1:0]);

  // Generator setup derived from control bits
  assign use_sec = time_base_select_ff && (HAS_SEC_BASE != 0);
  assign indep_mode = (output_mode_i == MODE_INDEP);
  assign center = center_align_enable_ff && independent_period_select_ff;
  assign period = independent_period_select_ff ? primary_phase_value_ff : master_period_ff;
  assign duty_src = shared_duty_select_ff ? shared_duty_ff : primary_duty_value_ff;
  assign duty_h = clamp_duty(duty_src, period, center);
  // Low output uses the secondary duty only in independent mode
  assign duty_l = indep_mode ? clamp_duty(shared_duty_select_ff ? shared_duty_ff :
    secondary_duty_value_ff, period, center) : duty_h;
  assign ext_rst = external_period_reset_ff && independent_period_select_ff &&
    !current_limit_mode_i && limit_pending_i;
  assign gen_tick = use_sec ? sec_base_tick_i : tick;
  assign wdat = wb_dat_i[15:0];
  // Byte-merged images of the compare and chop words
  assign cmp_merge = merge16({secondary_event_compare_value_ff, 3'h0}, wdat, wb_sel_i[1:0]);
  assign chop_merge = merge16({6'h00, chop_divider_ff, 3'h0}, wdat, wb_sel_i[1:0]);

  // Prescaler and chop clock
  pgc_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .prescale_i(input_clock_prescaler_ff),
    .chop_en_i(chop_generator_enable_ff),
    .chop_div_i(chop_divider_ff),
    .tick_o(tick),
    .chop_o(chop)
  );

  // Generator time base and comparators
  pgc_core u_core (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(gen_tick),
    .run_i(module_master_enable_ff),
    .center_i(center),
    .ext_rst_i(ext_rst),
    .immediate_i(immediate_update_ff),
    .period_i(period),
    .duty_h_i(duty_h),
    .duty_l_i(duty_l),
    .cmp_i({secondary_event_compare_value_ff, 3'h0}),
    .high_o(core_high),
    .low_o(core_low),
    .cycle_end_o(cycle_end),
    .match_o(match),
    .count_o(count)
  );

  // Register writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      input_clock_prescaler_ff <= 3'h0;
      module_master_enable_ff <= 1'b0;
      master_period_ff <= `PGC_RST_PERIOD;
      secondary_event_compare_value_ff <= 13'h0000;
      chop_generator_enable_ff <= 1'b0;
      chop_divider_ff <= 7'h00;
      shared_duty_ff <= `PGC_RST_ZERO;
      protection_key_value_ff <= `PGC_RST_ZERO;
      fault_irq_enable_ff <= 1'b0;
      limit_irq_enable_ff <= 1'b0;
      trigger_irq_enable_ff <= 1'b0;
      independent_period_select_ff <= 1'b0;
      shared_duty_select_ff <= 1'b0;
      dead_time_control_ff <= DTC_POS;
      time_base_select_ff <= 1'b0;
      center_align_enable_ff <= 1'b0;
      external_period_reset_ff <= 1'b0;
      immediate_update_ff <= 1'b0;
      primary_duty_value_ff <= `PGC_RST_ZERO;
      secondary_duty_value_ff <= `PGC_RST_ZERO;
      primary_phase_value_ff <= `PGC_RST_ZERO;
      secondary_phase_value_ff <= `PGC_RST_ZERO;
    end else if (wr) begin
      case (wb_adr_i)
        `PGC_OFS_TIMEBASE: begin
          if (wb_sel_i[0]) begin
            input_clock_prescaler_ff <= wdat[`PGC_TB_PRESCALE_HI:`PGC_TB_PRESCALE_LO];
          end
          if (wb_sel_i[1]) begin
            module_master_enable_ff <= wdat[`PGC_TB_ENABLE_BIT];
          end
        end
        `PGC_OFS_PERIOD: master_period_ff <= merge16(master_period_ff, wdat, wb_sel_i[1:0]);
        `PGC_OFS_SEC_CMP: begin
          secondary_event_compare_value_ff <= cmp_merge[`PGC_CMP_HI:`PGC_CMP_LO];
        end
        `PGC_OFS_CHOP: begin
          if (wb_sel_i[1]) begin
            chop_generator_enable_ff <= wdat[`PGC_CHOP_EN_BIT];
          end
          chop_divider_ff <= chop_merge[`PGC_CHOP_DIV_HI:`PGC_CHOP_DIV_LO];
        end
        `PGC_OFS_SHARED_DUTY: shared_duty_ff <= merge16(shared_duty_ff, wdat, wb_sel_i[1:0]);
        `PGC_OFS_KEY: begin
          protection_key_value_ff <= merge16(protection_key_value_ff, wdat,
            wb_sel_i[1:0]);
        end
        `PGC_OFS_GEN_CTRL: begin
          fault_irq_enable_ff <= nxt_ctrl[`PGC_CTL_FAULT_IEN];
          limit_irq_enable_ff <= nxt_ctrl[`PGC_CTL_LIMIT_IEN];
          trigger_irq_enable_ff <= nxt_ctrl[`PGC_CTL_TRIG_IEN];
          independent_period_select_ff <= nxt_ctrl[`PGC_CTL_INDEP];
          shared_duty_select_ff <= nxt_ctrl[`PGC_CTL_SHARED];
          dead_time_control_ff <= nxt_ctrl[`PGC_CTL_DTC_HI:`PGC_CTL_DTC_LO];
          time_base_select_ff <= nxt_ctrl[`PGC_CTL_TBSEL];
          center_align_enable_ff <= nxt_ctrl[`PGC_CTL_CENTER];
          external_period_reset_ff <= nxt_ctrl[`PGC_CTL_EXTRST];
          immediate_update_ff <= nxt_ctrl[`PGC_CTL_IMMED];
        end
        `PGC_OFS_PRI_DUTY: begin
          primary_duty_value_ff <= merge16(primary_duty_value_ff, wdat, wb_sel_i[1:0]);
        end
        `PGC_OFS_SEC_DUTY: begin
          secondary_duty_value_ff <= merge16(secondary_duty_value_ff, wdat, wb_sel_i[1:0]);
        end
        `PGC_OFS_PRI_PHASE: begin
          primary_phase_value_ff <= merge16(primary_phase_value_ff, wdat, wb_sel_i[1:0]);
        end
        `PGC_OFS_SEC_PHASE: begin
          secondary_phase_value_ff <= merge16(secondary_phase_value_ff, wdat, wb_sel_i[1:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // Interrupt flags: hardware set wins, disabling the source clears
  always @(posedge clk_i) begin
    if (rst_i) begin
      fault_irq_flag_ff <= 1'b0;
      limit_irq_flag_ff <= 1'b0;
      trigger_irq_flag_ff <= 1'b0;
      gen_irq_o <= 1'b0;
    end else begin
      if (fault_irq_enable_ff && fault_pending_i) begin
        fault_irq_flag_ff <= 1'b1;
      end else if (!fault_irq_enable_ff) begin
        fault_irq_flag_ff <= 1'b0;
      end
      if (limit_irq_enable_ff && limit_pending_i) begin
        limit_irq_flag_ff <= 1'b1;
      end else if (!limit_irq_enable_ff) begin
        limit_irq_flag_ff <= 1'b0;
      end
      if (trigger_irq_enable_ff && cycle_end) begin
        trigger_irq_flag_ff <= 1'b1;
      end else if (!trigger_irq_enable_ff) begin
        trigger_irq_flag_ff <= 1'b0;
      end
      gen_irq_o <= fault_irq_flag_ff || limit_irq_flag_ff || trigger_irq_flag_ff;
    end
  end

  // Read multiplexer
  always @* begin
    rd_val = 16'h0000;
    case (wb_adr_i)
      `PGC_OFS_TIMEBASE: rd_val = {module_master_enable_ff, 12'h000, input_clock_prescaler_ff};
      `PGC_OFS_PERIOD: rd_val = master_period_ff;
      `PGC_OFS_SEC_CMP: rd_val = {secondary_event_compare_value_ff, 3'h0};
      `PGC_OFS_CHOP: rd_val = {chop_generator_enable_ff, 5'h00, chop_divider_ff, 3'h0};
      `PGC_OFS_SHARED_DUTY: rd_val = shared_duty_ff;
      `PGC_OFS_KEY: rd_val = protection_key_value_ff;
      `PGC_OFS_GEN_CTRL: rd_val = {fault_irq_flag_ff, limit_irq_flag_ff, trigger_irq_flag_ff,
        fault_irq_enable_ff, limit_irq_enable_ff, trigger_irq_enable_ff,
        independent_period_select_ff, shared_duty_select_ff, dead_time_control_ff, 2'h0,
        time_base_select_ff, center_align_enable_ff, external_period_reset_ff,
        immediate_update_ff};
      `PGC_OFS_PRI_DUTY: rd_val = primary_duty_value_ff;
      `PGC_OFS_SEC_DUTY: rd_val = secondary_duty_value_ff;
      `PGC_OFS_PRI_PHASE: rd_val = primary_phase_value_ff;
      `PGC_OFS_SEC_PHASE: rd_val = secondary_phase_value_ff;
      `PGC_OFS_COUNT: rd_val = use_sec ? sec_base_count_i : count;
      default: rd_val = 16'h0000;
    endcase
  end

  // Bus answer one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wr || rd;
      wb_dat_o <= rd ? {16'h0000, rd_val} : 32'h00000000;
    end
  end

  // Dead-time shaping of the raw comparator outputs
  always @* begin
    nxt_high = core_high;
    nxt_low = indep_mode ? core_low : !core_high;
    case (dead_time_control_ff)
      DTC_POS: begin
        nxt_high = core_high && high_dly_ff;
        nxt_low = indep_mode ? core_low : (!core_high && low_dly_ff);
      end
      DTC_NEG: begin
        if (output_mode_i == 2'h0) begin
          nxt_high = core_high || high_dly_ff;
          nxt_low = !core_high || low_dly_ff;
        end
      end
      DTC_OFF: begin
        nxt_high = core_high;
      end
      default: begin
        nxt_high = core_high;
      end
    endcase
  end

  // Delay stage and registered outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      high_dly_ff <= 1'b0;
      low_dly_ff <= 1'b0;
      high_output_o <= 1'b0;
      low_output_o <= 1'b0;
      chop_clk_o <= 1'b0;
      special_event_o <= 1'b0;
    end else begin
      if (gen_tick) begin
        high_dly_ff <= core_high;
        low_dly_ff <= indep_mode ? core_low : !core_high;
      end
      high_output_o <= module_master_enable_ff && nxt_high;
      low_output_o <= module_master_enable_ff && nxt_low;
      chop_clk_o <= chop;
      special_event_o <= match;
    end
  end
endmodule // pgc_top
`default_nettype wire

// [pgc_regs.vh]
// Register offsets, field positions, reset values and timing counts of the PWM generator
`ifndef PGC_REGS_VH
`define PGC_REGS_VH
// Word offsets on the Wishbone bus (byte addresses)
`define PGC_OFS_TIMEBASE 8'h00
`define PGC_OFS_PERIOD 8'h04
`define PGC_OFS_SEC_CMP 8'h08
`define PGC_OFS_CHOP 8'h0c
`define PGC_OFS_SHARED_DUTY 8'h10
`define PGC_OFS_KEY 8'h14
`define PGC_OFS_GEN_CTRL 8'h18
`define PGC_OFS_PRI_DUTY 8'h1c
`define PGC_OFS_SEC_DUTY 8'h20
`define PGC_OFS_PRI_PHASE 8'h24
`define PGC_OFS_SEC_PHASE 8'h28
`define PGC_OFS_COUNT 8'h2c
// Time base register fields
`define PGC_TB_ENABLE_BIT 15
`define PGC_TB_PRESCALE_HI 2
`define PGC_TB_PRESCALE_LO 0
// Compare and chop fields
`define PGC_CMP_HI 15
`define PGC_CMP_LO 3
`define PGC_CHOP_EN_BIT 15
`define PGC_CHOP_DIV_HI 9
`define PGC_CHOP_DIV_LO 3
// Generator control fields
`define PGC_CTL_FAULT_FLAG 15
`define PGC_CTL_LIMIT_FLAG 14
`define PGC_CTL_TRIG_FLAG 13
`define PGC_CTL_FAULT_IEN 12
`define PGC_CTL_LIMIT_IEN 11
`define PGC_CTL_TRIG_IEN 10
`define PGC_CTL_INDEP 9
`define PGC_CTL_SHARED 8
`define PGC_CTL_DTC_HI 7
`define PGC_CTL_DTC_LO 6
`define PGC_CTL_TBSEL 3
`define PGC_CTL_CENTER 2
`define PGC_CTL_EXTRST 1
`define PGC_CTL_IMMED 0
// Reset values
`define PGC_RST_ZERO 16'h0000
`define PGC_RST_PERIOD 16'hffff
// Duty limits and timing counts
`define PGC_DUTY_MIN 16'h0008
`define PGC_LSB_NS 1.04
`define PGC_CMP_RES_NS 8.32
`define PGC_CHOP_UNIT_NS 16.64
`define PGC_CHOP_HALF_TICKS 8
`define PGC_EDGE_BAND_NS 40
`endif

// [pgc_prescaler.v]
// Input clock prescaler and chop clock generator
`default_nettype none
`include "pgc_regs.vh"
module pgc_prescaler (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Configuration
  input wire [2:0] prescale_i,
  input wire chop_en_i,
  input wire [6:0] chop_div_i,
  // Results
  output reg tick_o,
  output reg chop_o
);
  reg [5:0] div_cnt_ff;
  reg [9:0] chop_cnt_ff;
  wire [5:0] div_last;
  wire [9:0] chop_last;
  wire reserved;

  // Divide ratio minus one; code 111 gives no ticks
  assign div_last = (6'h01 << prescale_i) - 6'h01;
  assign reserved = (prescale_i == 3'h7);
  // Half chop period in prescaled ticks: 8 * (div + 1)
  assign chop_last = {chop_div_i, 3'h7};

  // Prescaled tick pulses
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_ff <= 6'h00;
      tick_o <= 1'b0;
    end else if (reserved) begin
      div_cnt_ff <= 6'h00;
      tick_o <= 1'b0;
    end else if (div_cnt_ff >= div_last) begin
      div_cnt_ff <= 6'h00;
      tick_o <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
      tick_o <= 1'b0;
    end
  end

  // Chop clock runs on prescaled ticks, only when enabled
  always @(posedge clk_i) begin
    if (rst_i || !chop_en_i) begin
      chop_cnt_ff <= 10'h000;
      chop_o <= 1'b0;
    end else if (tick_o) begin
      if (chop_cnt_ff >= chop_last) begin
        chop_cnt_ff <= 10'h000;
        chop_o <= ~chop_o;
      end else begin
        chop_cnt_ff <= chop_cnt_ff + 10'h001;
      end
    end
  end
endmodule // pgc_prescaler
`default_nettype wire

// [pgc_core.v]
// Generator time base, shadow registers and duty comparators
`default_nettype none
`include "pgc_regs.vh"
module pgc_core (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Timing control
  input wire tick_i,
  input wire run_i,
  input wire center_i,
  input wire ext_rst_i,
  input wire immediate_i,
  // Values
  input wire [15:0] period_i,
  input wire [15:0] duty_h_i,
  input wire [15:0] duty_l_i,
  input wire [15:0] cmp_i,
  // Results
  output reg high_o,
  output reg low_o,
  output reg cycle_end_o,
  output reg match_o,
  output reg [15:0] count_o
);
  reg [15:0] per_act_ff;
  reg [15:0] dh_act_ff;
  reg [15:0] dl_act_ff;
  reg down_ff;
  wire at_end;
  wire load;

  // End of cycle: top in edge mode, bottom on the way down in center mode
  assign at_end = center_i ? (down_ff && count_o == 16'h0000) : (count_o >= per_act_ff);
  // Shadows follow at once, or at the cycle boundary
  assign load = immediate_i || (tick_i && run_i && (at_end || ext_rst_i));

  // Active copies of period and duties
  always @(posedge clk_i) begin
    if (rst_i) begin
      per_act_ff <= `PGC_RST_PERIOD;
      dh_act_ff <= `PGC_RST_ZERO;
      dl_act_ff <= `PGC_RST_ZERO;
    end else if (load) begin
      per_act_ff <= period_i;
      dh_act_ff <= duty_h_i;
      dl_act_ff <= duty_l_i;
    end
  end

  // Counter, up in edge mode, up and down in center mode
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      count_o <= 16'h0000;
      down_ff <= 1'b0;
      cycle_end_o <= 1'b0;
      match_o <= 1'b0;
    end else begin
      cycle_end_o <= tick_i && (at_end || ext_rst_i);
      match_o <= tick_i && (count_o == cmp_i);
      if (tick_i) begin
        if (ext_rst_i) begin
          count_o <= 16'h0000;
          down_ff <= 1'b0;
        end else if (at_end) begin
          count_o <= 16'h0000;
          down_ff <= 1'b0;
        end else if (center_i && !down_ff && count_o >= per_act_ff) begin
          down_ff <= 1'b1;
          count_o <= count_o - 16'h0001;
        end else if (down_ff) begin
          count_o <= count_o - 16'h0001;
        end else begin
          count_o <= count_o + 16'h0001;
        end
      end
    end
  end

  // Duty comparators
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      high_o <= 1'b0;
      low_o <= 1'b0;
    end else begin
      high_o <= count_o < dh_act_ff;
      low_o <= count_o < dl_act_ff;
    end
  end
endmodule // pgc_core
`default_nettype wire

// [pgc_checker.sv]
// Bus and output assertions for the PWM generator block
`default_nettype none
module pgc_checker #(
  parameter HAS_SEC_BASE = 0
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Neighbouring blocks
  input wire [1:0] output_mode_i,
  input wire current_limit_mode_i,
  input wire fault_pending_i,
  input wire limit_pending_i,
  input wire [15:0] sec_base_count_i,
  input wire sec_base_tick_i,
  // Power stage and events
  input wire high_output_o,
  input wire low_output_o,
  input wire chop_clk_o,
  input wire special_event_o,
  input wire gen_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Taken request, read answer, upper-lane write
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd = wb_ack_o && !wb_we_i;
  wire wr_hi = req && wb_we_i && wb_sel_i[1];
  // Bus answer timing and data lanes
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside answer");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read lanes not zero");
  // Unimplemented register bits
  a_cmp_low: assert property (rd && wb_adr_i == 8'h08 |-> wb_dat_o[2:0] == 3'h0)
    else $error("compare low bits not zero");
  a_chop_resv: assert property (rd && wb_adr_i == 8'h0c |-> (wb_dat_o[15:0] & 16'h7c07) == 16'h0)
    else $error("chop reserved bits not zero");
  // Chop stop and flag clearing
  a_chop_stop: assert property (wr_hi && wb_adr_i == 8'h0c && !wb_dat_i[15]
    |-> ##3 (!chop_clk_o) [*4])
    else $error("chop clock runs while disabled");
  a_irq_clear: assert property (wr_hi && wb_adr_i == 8'h18 && wb_dat_i[12:10] == 3'h0
    |-> ##[1:3] !gen_irq_o)
    else $error("request stays after enables cleared");
  // Special event is a single-cycle pulse
  a_event_pulse: assert property (special_event_o |=> !special_event_o)
    else $error("special event wider than one cycle");
  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(chop_clk_o));
  cover property ($rose(gen_irq_o));
endmodule // pgc_checker
bind pgc_top pgc_checker #(.HAS_SEC_BASE(HAS_SEC_BASE)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .output_mode_i(output_mode_i), .current_limit_mode_i(current_limit_mode_i),
  .fault_pending_i(fault_pending_i), .limit_pending_i(limit_pending_i),
  .sec_base_count_i(sec_base_count_i), .sec_base_tick_i(sec_base_tick_i),
  .high_output_o(high_output_o), .low_output_o(low_output_o), .chop_clk_o(chop_clk_o),
  .special_event_o(special_event_o), .gen_irq_o(gen_irq_o));
`default_nettype wire

// [pgc_stage.sv]
// Power stage model measuring the on-time of both switches
`default_nettype none
module pgc_stage (
  // Clock
  input wire clk_i,
  // Gate drives
  input wire high_i,
  input wire low_i,
  // Measured on-times
  output logic [15:0] high_w_o,
  output logic [15:0] low_w_o,
  output logic high_done_o,
  output logic low_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hc;
  logic [15:0] lc;
  // Count on-time, report it when the switch opens
  always @(posedge clk_i) begin
    hc <= high_i ? hc + 16'h1 : 16'h0;
    lc <= low_i ? lc + 16'h1 : 16'h0;
    high_done_o <= !high_i && hc != 16'h0;
    low_done_o <= !low_i && lc != 16'h0;
    high_w_o <= hc;
    low_w_o <= lc;
  end
endmodule // pgc_stage
`default_nettype wire

// [tb.sv]
// Self-checking bench for the PWM generator block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [1:0] mode = 2'h0;
  logic fault_p = 1'b0, limit_p = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, high_o, low_o, chop_o, irq_o, hd, ld, cd;
  wire [15:0] hw, lw, cw;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] rq[$], qh[$], ql[$], qc[$];
  logic [15:0] d;
  logic [7:0] ra [7] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  logic [15:0] rm [7] = '{16'hfff8, 16'h83f8, 16'hffff, 16'hffff, 16'h1fcf, 16'hffff, 16'hffff};
  // Cases: mode, control, primary, secondary, shared, high width, low width
  logic [15:0] cs [4][7] = '{'{0, 16'h0080, 16'h0002, 0, 0, 8, 57},
    '{0, 16'h0080, 16'h003f, 0, 0, 56, 9}, '{0, 16'h0180, 16'h0020, 0, 16'h0010, 16, 49},
    '{3, 16'h0080, 16'h0020, 16'h0018, 0, 32, 24}};
  // 125 MHz clock
  always #4 clk_i = ~clk_i;
  pgc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .output_mode_i(mode),
    .current_limit_mode_i(1'b0), .fault_pending_i(fault_p), .limit_pending_i(limit_p),
    .sec_base_count_i(16'h0), .sec_base_tick_i(1'b0), .high_output_o(high_o),
    .low_output_o(low_o), .chop_clk_o(chop_o), .special_event_o(), .gen_irq_o(irq_o));
  pgc_stage stage (.clk_i(clk_i), .high_i(high_o), .low_i(low_o), .high_w_o(hw),
    .low_w_o(lw), .high_done_o(hd), .low_done_o(ld));
  pgc_stage chop_meter (.clk_i(clk_i), .high_i(chop_o), .low_i(1'b0), .high_w_o(cw),
    .low_w_o(), .high_done_o(cd), .low_done_o());
  // Compare one result
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic cycle; a read notes its expected value
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] v);
    if (!w) rq.push_back({16'h0, v});
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'h3;
    wb_dat <= {16'h0, v};
    for (int i = 0; i < 50 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Result watcher
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && !wb_we && rq.size() > 0) chk("rdata", rq.pop_front(), wb_dat_o);
    if (hd === 1'b1 && qh.size() > 0) chk("high_width", qh.pop_front(), hw);
    if (ld === 1'b1 && ql.size() > 0) chk("low_width", ql.pop_front(), lw);
    if (cd === 1'b1 && qc.size() > 0) chk("chop_width", qc.pop_front(), cw);
  end
  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
  // Main sequence
  initial begin
    d = $urandom(32'h64345e58);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h04, 16'hffff);
    foreach (ra[i]) wb(0, ra[i], 16'h0000);
    foreach (ra[i]) begin
      d = $urandom;
      wb(1, ra[i], d);
      wb(0, ra[i], d & rm[i]);
    end
    wb(1, 8'h40, 16'hffff);
    wb(0, 8'h40, 16'h0000);
    // Flags: only the enabled one sets, clearing the enable clears it
    wb(1, 8'h04, 16'h0040);
    wb(1, 8'h00, 16'h8000);
    fault_p <= 1'b1;
    limit_p <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wb(1, 8'h18, 16'h0400 << i);
      repeat (150) @(posedge clk_i);
      chk("irq", 1, irq_o);
      wb(0, 8'h18, 16'h2400 << i);
      wb(1, 8'h18, 16'h0000);
      wb(0, 8'h18, 16'h0000);
    end
    fault_p <= 1'b0;
    limit_p <= 1'b0;
    // Pulse widths per duty source and output mode
    wb(1, 8'h08, 16'h0010);
    foreach (cs[i]) begin
      mode <= cs[i][0][1:0];
      wb(1, 8'h00, 16'h0000);
      wb(1, 8'h10, cs[i][4]);
      wb(1, 8'h1c, cs[i][2]);
      wb(1, 8'h20, cs[i][3]);
      wb(1, 8'h18, cs[i][1]);
      wb(1, 8'h00, 16'h8000);
      repeat (200) @(posedge clk_i);
      qh.push_back(cs[i][5]);
      ql.push_back(cs[i][6]);
      repeat (150) @(posedge clk_i);
    end
    // Chop width at two prescaler settings
    for (int p = 0; p < 2; p++) begin
      wb(1, 8'h00, 16'h8000 | p);
      wb(1, 8'h0c, 16'h8010);
      repeat (200) @(posedge clk_i);
      qc.push_back(24 << p);
      repeat (200) @(posedge clk_i);
    end
    wb(1, 8'h0c, 16'h0000);
    repeat (20) @(posedge clk_i);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
